// ===== sim/pgc_pads.sv
// pad model: weak external source behind each pin
`timescale 1ns/100ps
module pgc_pads #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] ext,
  output logic      [W-1:0] level
);
  // the chip driver overrides the resistor-fed external source
  assign level = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// ===== sim/pgc_props.sv
// port checker for the pin group block
`timescale 1ns/100ps
module pgc_props (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] group_a_pins_oe,
  input wire logic [7:0] group_a_pull_en,
  input wire logic [7:0] group_a_irq_en,
  input wire logic [6:0] group_b_pins_oe,
  input wire logic [6:0] group_b_pull_en,
  input wire logic [6:0] group_b_irq_en,
  input wire logic [1:0] group_c_pins_out,
  input wire logic [1:0] group_c_pins_oe,
  input wire logic [1:0] group_c_osc_use
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // writes that turn every pin of a group into an input
  sequence a_dir_zero;
    reg_wr && reg_addr == 8'h01 && reg_wdata == 8'h00;
  endsequence
  sequence c_dir_zero;
    reg_wr && reg_addr == 8'h07 && reg_wdata[1:0] == 2'h0;
  endsequence

  rd_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
  rd_unmap_a: assert property (
    $past(reg_rd) && $past(reg_addr) > 8'h09 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  c_upper_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h06 |-> reg_rdata[7:2] == 6'h00)
    else $error("group c upper bits set");
  a_mode_a: assert property (
    (group_a_pull_en & group_a_pins_oe) == 8'h00)
    else $error("group a pull on a driven pin");
  b_mode_a: assert property (
    (group_b_pull_en & group_b_pins_oe) == 7'h00)
    else $error("group b pull on a driven pin");
  irq_pull_a: assert property (
    (group_a_irq_en & ~group_a_pull_en) == 8'h00 &&
    (group_b_irq_en & ~group_b_pull_en) == 7'h00)
    else $error("interrupt input without pull-up");
  osc_force_a: assert property (
    (group_c_osc_use & (group_c_pins_oe | group_c_pins_out)) == 2'h0)
    else $error("oscillator pin driven");
  // the strap lands at the first edge after release, so only edges
  // with two cycles of reset-free history may demand a steady copy
  osc_hold_a: assert property (
    $past(arst_n) && $past(arst_n, 2) |-> $stable(group_c_osc_use))
    else $error("oscillator choice moved");
  a_dir_pad_a: assert property (
    a_dir_zero |-> ##2 group_a_pins_oe == 8'h00)
    else $error("group a still driven");
  c_dir_pad_a: assert property (
    c_dir_zero |-> ##2 group_c_pins_oe == 2'h0)
    else $error("group c still driven");
endmodule

// ===== sim/testbench.sv
// self-checking bench for the pin group block
`timescale 1ns/100ps
module testbench;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] osc_option = 2'h0, osc_m = 2'h0;
  logic [7:0] a_in, a_out, a_oe, a_pu, a_irq, ext_a = 8'h00;
  logic [6:0] b_in, b_out, b_oe, b_pu, b_irq, ext_b = 7'h00;
  logic [1:0] c_in, c_out, c_oe, c_osc, ext_c = 2'h0;
  logic [7:0] m [0:8] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
                          8'h03, 8'h00, 8'h0C};
  logic [31:0] lf = 32'h000155F9; // 87545
  int         fails = 0, checks_done = 0, cyc = 0;

  always #10 clk = ~clk;

  pgc_pin_groups DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .osc_option(osc_option),
    .group_a_pins_in(a_in), .group_a_pins_out(a_out),
    .group_a_pins_oe(a_oe), .group_a_pull_en(a_pu),
    .group_a_irq_en(a_irq), .group_b_pins_in(b_in),
    .group_b_pins_out(b_out), .group_b_pins_oe(b_oe),
    .group_b_pull_en(b_pu), .group_b_irq_en(b_irq),
    .group_c_pins_in(c_in), .group_c_pins_out(c_out),
    .group_c_pins_oe(c_oe), .group_c_osc_use(c_osc));
  pgc_pads #(.W(8)) pad_a (.pin_out(a_out), .pin_oe(a_oe), .ext(ext_a),
    .level(a_in));
  pgc_pads #(.W(7)) pad_b (.pin_out(b_out), .pin_oe(b_oe), .ext(ext_b),
    .level(b_in));
  pgc_pads #(.W(2)) pad_c (.pin_out(c_out), .pin_oe(c_oe), .ext(ext_c),
    .level(c_in));

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard, far above the roughly 1800 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      close_out;
    end
  end

  function automatic logic [7:0] rnd;
    repeat (8) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // input pins read live, output pins read the stored bit
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: return (m[0] & m[1]) | (ext_a & ~m[1]);
      8'h03: return (m[3] & m[4]) | ({1'b1, ext_b} & ~m[4]);
      8'h06: return ((m[6] & m[7]) | ({6'h00, ext_c} & ~m[7])) & 8'h03;
      8'h09: return {6'h00, osc_m};
      default: return (a < 8'h09) ? m[a] : 8'h00;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a < 8'h09) m[a] = v;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = exp_rd(a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge clk);
  endtask

  // pad controls of a standard group against its three registers
  task automatic chk_grp(input logic [7:0] oe, pu, irq, out, d, r, p,
                         input logic sel);
    chk(oe, r & (p | ~d));
    chk(pu, ~r & p);
    chk(irq, ~r & p & {8{sel}});
    chk(out & r, r & p & d);
  endtask

  // looks just after an edge, then lets the next edge pass so the
  // following request starts on a rising edge again
  task automatic chk_pads;
    #1;
    chk_grp(a_oe, a_pu, a_irq, a_out, m[0], m[1], m[2], m[8][0]);
    chk_grp({1'b0, b_oe}, {1'b0, b_pu}, {1'b0, b_irq}, {1'b0, b_out},
            m[3], m[4], m[5], m[8][1]);
    chk({6'h00, c_oe}, m[7]);
    chk({6'h00, c_out & m[7][1:0]}, m[7] & m[6]);
    @(posedge clk);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int a = 0; a < 10; a++) rd(a[7:0]);
    // turning group a to outputs shows the ones that reset left there
    wr(8'h01, 8'hFF);
    rd(8'h00);
    chk_pads;
    for (int i = 0; i < 40; i++) begin
      ext_a <= rnd();
      ext_b <= 7'(rnd());
      ext_c <= 2'(rnd());
      for (int a = 0; a < 3; a++) wr(a[7:0], rnd());
      wr(8'h03, rnd() | 8'h80);
      wr(8'h04, rnd() & 8'h7F);
      wr(8'h05, rnd() & 8'h7F);
      wr(8'h06, rnd() & 8'h03);
      wr(8'h07, rnd() & 8'h03);
      wr(8'h08, rnd());
      wr(rnd() | 8'h10, rnd());
      chk_pads;
      for (int a = 0; a < 10; a++) rd(a[7:0]);
      rd(rnd() | 8'h0A);
    end
    wr(8'h01, 8'h00);
    wr(8'h07, 8'h00);
    chk_pads;
    // second reset with both shared pins taken by the oscillator
    arst_n <= 1'b0;
    osc_option <= 2'h3;
    osc_m = 2'h3;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    osc_option <= 2'h0;
    wr(8'h07, 8'h03);
    wr(8'h06, 8'h03);
    rd(8'h09);
    #1 chk({6'h00, c_osc}, 8'h03);
    chk({4'h0, c_oe, c_out}, 8'h00);
    close_out;
  end
endmodule

bind pgc_pin_groups pgc_props u_props (.clk(clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .group_a_pins_oe(group_a_pins_oe), .group_a_pull_en(group_a_pull_en),
  .group_a_irq_en(group_a_irq_en), .group_b_pins_oe(group_b_pins_oe),
  .group_b_pull_en(group_b_pull_en), .group_b_irq_en(group_b_irq_en),
  .group_c_pins_out(group_c_pins_out), .group_c_pins_oe(group_c_pins_oe),
  .group_c_osc_use(group_c_osc_use));

// ===== verilog/pgc_defines.svh
// register offsets, reset values and encodings of the pin group block
`ifndef PGC_DEFINES_SVH
`define PGC_DEFINES_SVH

`define PGC_ADDR_W          8
`define PGC_OFF_A_DATA      8'h00
`define PGC_OFF_A_DIR       8'h01
`define PGC_OFF_A_PULL      8'h02
`define PGC_OFF_B_DATA      8'h03
`define PGC_OFF_B_DIR       8'h04
`define PGC_OFF_B_PULL      8'h05
`define PGC_OFF_C_DATA      8'h06
`define PGC_OFF_C_DIR       8'h07
`define PGC_OFF_IRQ_SEL     8'h08
`define PGC_OFF_OSC_STAT    8'h09

`define PGC_RST_DATA        8'hFF
`define PGC_RST_DIR         8'h00
`define PGC_RST_PULL        8'h00
`define PGC_RST_C_DATA      2'h3
`define PGC_RST_C_DIR       2'h0
`define PGC_RST_IRQ_SEL     8'h0C
`define PGC_ZERO8           8'h00

`define PGC_IRQ_SEL_A_BIT   0
`define PGC_IRQ_SEL_B_BIT   1

`endif

// ===== verilog/pgc_pin_cell.sv
// one pin: mode decode and registered pad controls
`timescale 1ns/100ps
module pgc_pin_cell #(
  parameter bit HAS_PULL = 1'b1
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic dir,
  input  wire logic pull,
  input  wire logic data,
  input  wire logic irq_cap,
  input  wire logic osc_use,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pull_en,
  output logic      irq_en
);

  pgc_pkg::pgc_mode_t mode;

  // a pin without a pull select bit acts as push-pull when driving
  always_comb begin
    if (HAS_PULL) begin
      mode = pgc_pkg::pgc_mode_t'({dir, pull});
    end else begin
      mode = dir ? pgc_pkg::PGC_PUSH_PULL
                 : pgc_pkg::PGC_FLOAT_IN;
    end
  end

  // pad controls held in flops so the pins never glitch on decode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
      pull_en <= 1'b0;
      irq_en  <= 1'b0;
    end else if (osc_use) begin
      // oscillator owns the pad, so the port lets go completely
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
      pull_en <= 1'b0;
      irq_en  <= 1'b0;
    end else begin
      unique case (mode)
        pgc_pkg::PGC_FLOAT_IN: begin
          pin_out <= 1'b0;
          pin_oe  <= 1'b0;
          pull_en <= 1'b0;
          irq_en  <= 1'b0;
        end
        pgc_pkg::PGC_PULL_IN: begin
          pin_out <= 1'b0;
          pin_oe  <= 1'b0;
          pull_en <= 1'b1;
          irq_en  <= irq_cap;
        end
        pgc_pkg::PGC_OPEN_DRN: begin
          pin_out <= 1'b0;
          pin_oe  <= ~data; // drive low only, release for one
          pull_en <= 1'b0;
          irq_en  <= 1'b0;
        end
        pgc_pkg::PGC_PUSH_PULL: begin
          pin_out <= data;
          pin_oe  <= 1'b1;
          pull_en <= 1'b0;
          irq_en  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ===== verilog/pgc_pin_groups.sv
// pin group configuration: registers, read mux and per-pin cells
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`include "pgc_defines.svh"
module pgc_pin_groups (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [1:0] osc_option,
  input  wire logic [7:0] group_a_pins_in,
  output logic      [7:0] group_a_pins_out,
  output logic      [7:0] group_a_pins_oe,
  output logic      [7:0] group_a_pull_en,
  output logic      [7:0] group_a_irq_en,
  input  wire logic [6:0] group_b_pins_in,
  output logic      [6:0] group_b_pins_out,
  output logic      [6:0] group_b_pins_oe,
  output logic      [6:0] group_b_pull_en,
  output logic      [6:0] group_b_irq_en,
  input  wire logic [1:0] group_c_pins_in,
  output logic      [1:0] group_c_pins_out,
  output logic      [1:0] group_c_pins_oe,
  output logic      [1:0] group_c_osc_use
);

  // register map, one byte per offset:
  //   00 group a data       01 group a direction
  //   02 group a pull       03 group b data
  //   04 group b direction  05 group b pull
  //   06 group c data       07 group c direction
  //   08 interrupt select   09 oscillator use, read only
  // any other offset ignores writes and reads back zero
  //
  // pad controls follow a register write by one clock, since every
  // pin cell registers its outputs; the oscillator strap is taken
  // once after each reset release, so moving it later has no effect
  // bits without a pin (group b bit 7, group c bits 7:2) hold their
  // value or read zero; software keeps them at reset values
  // interrupt select bit 0 serves group a, bit 1 group b, and the
  // upper bits are storage only

  logic [7:0] group_a_pin_data;
  logic [7:0] group_a_direction;
  logic [7:0] group_a_pull_select;
  logic [7:0] group_b_pin_data;
  logic [7:0] group_b_direction;
  logic [7:0] group_b_pull_select;
  logic [1:0] group_c_pin_data;
  logic [1:0] group_c_direction;
  logic [7:0] ext_irq_select_reg;
  logic       option_taken;
  logic [7:0] next_rdata;
  logic [7:0] a_read;
  logic [6:0] b_read;
  logic [1:0] c_read;
  logic       we_a_data;
  logic       we_a_dir;
  logic       we_a_pull;
  logic       we_b_data;
  logic       we_b_dir;
  logic       we_b_pull;
  logic       we_c_data;
  logic       we_c_dir;
  logic       we_irq_sel;

  // one write enable per register; an unmapped offset raises none,
  // so a stray write can never land in a neighbouring register, and
  // the read-only oscillator offset falls to the default as well
  always_comb begin
    we_a_data  = 1'b0;
    we_a_dir   = 1'b0;
    we_a_pull  = 1'b0;
    we_b_data  = 1'b0;
    we_b_dir   = 1'b0;
    we_b_pull  = 1'b0;
    we_c_data  = 1'b0;
    we_c_dir   = 1'b0;
    we_irq_sel = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        `PGC_OFF_A_DATA:  we_a_data  = 1'b1;
        `PGC_OFF_A_DIR:   we_a_dir   = 1'b1;
        `PGC_OFF_A_PULL:  we_a_pull  = 1'b1;
        `PGC_OFF_B_DATA:  we_b_data  = 1'b1;
        `PGC_OFF_B_DIR:   we_b_dir   = 1'b1;
        `PGC_OFF_B_PULL:  we_b_pull  = 1'b1;
        `PGC_OFF_C_DATA:  we_c_data  = 1'b1;
        `PGC_OFF_C_DIR:   we_c_dir   = 1'b1;
        `PGC_OFF_IRQ_SEL: we_irq_sel = 1'b1;
        default:          we_irq_sel = 1'b0;
      endcase
    end
  end

  // group a data; ones at reset so a pin switched to output
  // starts high, or released when open drain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      group_a_pin_data <= `PGC_RST_DATA;
    end else if (we_a_data) begin
      group_a_pin_data <= reg_wdata;
    end
  end

  // group a direction; zeros at reset so every pin starts as input
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      group_a_direction <= `PGC_RST_DIR;
    end else if (we_a_dir) begin
      group_a_direction <= reg_wdata;
    end
  end

  // group a pull select; cleared at reset, so inputs start
  // floating until software asks for the pull-up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      group_a_pull_select <= `PGC_RST_PULL;
    end else if (we_a_pull) begin
      group_a_pull_select <= reg_wdata;
    end
  end

  // group b data; bit 7 has no pin and only holds its value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      group_b_pin_data <= `PGC_RST_DATA;
    end else if (we_b_data) begin
      group_b_pin_data <= reg_wdata;
    end
  end

  // group b direction; bit 7 is stored but steers nothing,
  // so a one written there is harmless yet reads back
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      group_b_direction <= `PGC_RST_DIR;
    end else if (we_b_dir) begin
      group_b_direction <= reg_wdata;
    end
  end

  // group b pull select; same layout as group a, seven live bits
  // and one storage bit on top
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      group_b_pull_select <= `PGC_RST_PULL;
    end else if (we_b_pull) begin
      group_b_pull_select <= reg_wdata;
    end
  end

  // group c data, two bits; the upper write data bits are dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      group_c_pin_data <= `PGC_RST_C_DATA;
    end else if (we_c_data) begin
      group_c_pin_data <= reg_wdata[1:0];
    end
  end

  // group c direction, the only mode bit of the shared pins;
  // there is no pull select register for this group
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      group_c_direction <= `PGC_RST_C_DIR;
    end else if (we_c_dir) begin
      group_c_direction <= reg_wdata[1:0];
    end
  end

  // interrupt capability selection for the standard groups;
  // only bits 0 and 1 act, the rest are plain storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_irq_select_reg <= `PGC_RST_IRQ_SEL;
    end else if (we_irq_sel) begin
      ext_irq_select_reg <= reg_wdata;
    end
  end

  // option strap caught once after reset release, not at reset itself,
  // since an async reset may only load constants
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      option_taken    <= 1'b0;
      group_c_osc_use <= 2'h0;
    end else if (!option_taken) begin
      option_taken    <= 1'b1;
      group_c_osc_use <= osc_option;
    end
  end

  // data reads: stored bit where driving, pad level where listening
  assign a_read = (group_a_pin_data & group_a_direction)
                | (group_a_pins_in & ~group_a_direction);
  assign b_read = (group_b_pin_data[6:0] & group_b_direction[6:0])
                | (group_b_pins_in & ~group_b_direction[6:0]);
  assign c_read = (group_c_pin_data & group_c_direction)
                | (group_c_pins_in & ~group_c_direction);

  // read mux; unmapped offsets return zero
  always_comb begin
    next_rdata = `PGC_ZERO8;
    if (reg_rd) begin
      unique case (reg_addr)
        `PGC_OFF_A_DATA:   next_rdata = a_read;
        `PGC_OFF_A_DIR:    next_rdata = group_a_direction;
        `PGC_OFF_A_PULL:   next_rdata = group_a_pull_select;
        `PGC_OFF_B_DATA:   next_rdata = {group_b_pin_data[7], b_read};
        `PGC_OFF_B_DIR:    next_rdata = group_b_direction;
        `PGC_OFF_B_PULL:   next_rdata = group_b_pull_select;
        `PGC_OFF_C_DATA:   next_rdata = {6'h00, c_read};
        `PGC_OFF_C_DIR:    next_rdata = {6'h00, group_c_direction};
        `PGC_OFF_IRQ_SEL:  next_rdata = ext_irq_select_reg;
        `PGC_OFF_OSC_STAT: next_rdata = {6'h00, group_c_osc_use};
        default:           next_rdata = `PGC_ZERO8;
      endcase
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `PGC_ZERO8;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // group a pin cells
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_a
      pgc_pin_cell #(.HAS_PULL(1'b1)) u_cell (
        .clk     (clk),
        .arst_n  (arst_n),
        .dir     (group_a_direction[gi]),
        .pull    (group_a_pull_select[gi]),
        .data    (group_a_pin_data[gi]),
        .irq_cap (ext_irq_select_reg[`PGC_IRQ_SEL_A_BIT]),
        .osc_use (1'b0),
        .pin_out (group_a_pins_out[gi]),
        .pin_oe  (group_a_pins_oe[gi]),
        .pull_en (group_a_pull_en[gi]),
        .irq_en  (group_a_irq_en[gi])
      );
    end
  endgenerate

  // group b pin cells
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_b
      pgc_pin_cell #(.HAS_PULL(1'b1)) u_cell (
        .clk     (clk),
        .arst_n  (arst_n),
        .dir     (group_b_direction[gi]),
        .pull    (group_b_pull_select[gi]),
        .data    (group_b_pin_data[gi]),
        .irq_cap (ext_irq_select_reg[`PGC_IRQ_SEL_B_BIT]),
        .osc_use (1'b0),
        .pin_out (group_b_pins_out[gi]),
        .pin_oe  (group_b_pins_oe[gi]),
        .pull_en (group_b_pull_en[gi]),
        .irq_en  (group_b_irq_en[gi])
      );
    end
  endgenerate

  // group c cells: no pull bit and interrupt capability tied off
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_c
      pgc_pin_cell #(.HAS_PULL(1'b0)) u_cell (
        .clk     (clk),
        .arst_n  (arst_n),
        .dir     (group_c_direction[gi]),
        .pull    (1'b0),
        .data    (group_c_pin_data[gi]),
        .irq_cap (1'b0),
        .osc_use (group_c_osc_use[gi]),
        .pin_out (group_c_pins_out[gi]),
        .pin_oe  (group_c_pins_oe[gi]),
        .pull_en (),
        .irq_en  ()
      );
    end
  endgenerate

endmodule

// ===== verilog/pgc_pkg.sv
// types shared by the pin group block
package pgc_pkg;

  // pin mode, encoded as {direction, pull select}
  typedef enum logic [1:0] {
    PGC_FLOAT_IN  = 2'h0,
    PGC_PULL_IN   = 2'h1,
    PGC_OPEN_DRN  = 2'h2,
    PGC_PUSH_PULL = 2'h3
  } pgc_mode_t;

endpackage
